/* logic/mcu_operand_address_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "operand_decoder_regs.svh"
module mcu_operand_address_decoder #(
   parameter int STACK_CELLS = `STACK_DEPTH
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // program space read port
   output var  logic [11:0] pm_addr,
   input  wire logic [7:0]  pm_rdata,
   // data space bus
   output var  logic [7:0]  dm_addr,
   output var  logic [7:0]  dm_wdata,
   output var  logic        dm_we,
   output var  logic        dm_rd,
   input  wire logic [7:0]  dm_rdata,
   // core status
   output var  logic [7:0]  acc,
   output var  logic        zero_flag,
   output var  logic        carry_flag,
   output var  logic        opcode_fetch
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [11:0] pc_q, pc_d, pma_q, pma_d;
   logic [2:0]  cyc_q, cyc_d;
   logic [7:0]  op_q, op_d, b1_q, b1_d, b2_q, b2_d;
   logic [7:0]  acc_q, acc_d, dma_q, dma_d, dmw_q, dmw_d;
   logic [7:0]  cell_q [4];
   logic [7:0]  cell_d [4];
   logic [11:0] stk_q [STACK_CELLS];
   logic [11:0] stk_d [STACK_CELLS];
   logic        zf_q, zf_d, cf_q, cf_d, dwe_q, dwe_d, drd_q, drd_d;
   logic        fetch_q, fetch_d, tbit_q, tbit_d;
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   logic [7:0]  op_w, rd_w, ea_w, wv_w;
   logic [3:0]  form_w;
   logic [11:0] nxt_w, rel_w;
   logic        last_w, cond_w, wr_w, rdn_w;
   operand_decoder_pkg::op_class_t cls_w;

   // one data space map for every access path
   function automatic logic is_cell(input logic [7:0] a);
      return a[7:2] == `CELL_BASE_HI;
   endfunction : is_cell

   function automatic logic is_int(input logic [7:0] a);
      return is_cell(a) || a == `ACC_ADDR;
   endfunction : is_int

   // opcode is read straight off program space in its own fetch cycle
   assign op_w   = fetch_q ? pm_rdata : op_q;
   assign cls_w  = operand_decoder_pkg::op_class(op_w);
   assign form_w = op_w[3:0];
   assign last_w = cyc_q == operand_decoder_pkg::op_cycles(op_w) - 3'h1;
   // internal cells answer at once, so the bus is never read for them
   assign rd_w = (dma_q == `ACC_ADDR) ? acc_q :
                 is_cell(dma_q) ? cell_q[dma_q[1:0]] : dm_rdata;

   // relative condition and target from opcode fields
   always_comb begin
      unique case (op_q[6:5])
         2'h0: cond_w = !zf_q;
         2'h1: cond_w = !cf_q;
         2'h2: cond_w = zf_q;
         2'h3: cond_w = cf_q;
      endcase
      if (op_q[`OP_DIR_BIT])
         rel_w = pc_q - {8'h00, op_q[3:0]};
      else
         rel_w = pc_q + 12'h001 + {8'h00, op_q[3:0]};
   end

   // effective address, formed while the second byte arrives
   always_comb begin
      ea_w  = pm_rdata;
      rdn_w = 1'b0;
      if (cls_w == operand_decoder_pkg::CL_LDST) begin
         if (!form_w[3])
            ea_w = {`CELL_BASE_HI, form_w[1:0]};
         else if (form_w == `LDF_IND_LD || form_w == `LDF_IND_ST)
            ea_w = cell_q[{1'b0, op_w[`OP_PTR_BIT]}];
         rdn_w = form_w[3:2] == 2'h0 || form_w == `LDF_IND_LD
                 || form_w == `LDF_DIR_LD;
      end else if (cls_w == operand_decoder_pkg::CL_BDIR
                   || cls_w == operand_decoder_pkg::CL_BTST) begin
         rdn_w = 1'b1;
      end
   end

   // write value and write request in the execute cycle
   always_comb begin
      wv_w = acc_q;
      wr_w = 1'b0;
      if (cls_w == operand_decoder_pkg::CL_LDST) begin
         wr_w = (form_w[3:2] == 2'h1) || form_w == `LDF_IND_ST
                || form_w == `LDF_DIR_ST || form_w == `LDF_IMM_MEM;
         if (form_w == `LDF_IMM_MEM)
            wv_w = pm_rdata;
      end else if (cls_w == operand_decoder_pkg::CL_BDIR) begin
         wr_w = 1'b1;
         wv_w = rd_w;
         wv_w[op_q[2:0]] = op_q[`OP_POL_BIT];
      end
   end

   // ----------------------------------------
   // sequencer next state
   // ----------------------------------------
   always_comb begin
      pc_d    = pc_q;
      cyc_d   = cyc_q + 3'h1;
      pma_d   = pc_q + 12'(cyc_q) + 12'h001;
      op_d    = op_q;
      b1_d    = b1_q;
      b2_d    = b2_q;
      acc_d   = acc_q;
      cell_d  = cell_q;
      stk_d   = stk_q;
      zf_d    = zf_q;
      cf_d    = cf_q;
      dma_d   = dma_q;
      dmw_d   = dmw_q;
      dwe_d   = 1'b0;
      drd_d   = 1'b0;
      tbit_d  = tbit_q;
      nxt_w   = pc_q + 12'(operand_decoder_pkg::op_bytes(op_w));
      unique case (cyc_q)
         3'h0: op_d = pm_rdata;
         3'h1: begin
            b1_d  = pm_rdata;
            dma_d = ea_w;
            drd_d = rdn_w && !is_int(ea_w);
         end
         3'h2: begin
            b2_d = pm_rdata;
            if (cls_w == operand_decoder_pkg::CL_LDST) begin
               if (rdn_w) begin
                  acc_d = rd_w;
                  zf_d  = rd_w == 8'h00;
               end else if (form_w == `LDF_IMM_ACC) begin
                  acc_d = b1_q;
                  zf_d  = b1_q == 8'h00;
               end else if (wr_w && form_w != `LDF_IMM_MEM) begin
                  zf_d  = acc_q == 8'h00;
               end
            end
            if (cls_w == operand_decoder_pkg::CL_BTST) begin
               tbit_d = rd_w[op_q[2:0]] == op_q[`OP_POL_BIT];
               cf_d   = rd_w[op_q[2:0]];
            end
            if (wr_w) begin
               if (dma_q == `ACC_ADDR) begin
                  acc_d = wv_w;
               end else if (is_cell(dma_q)) begin
                  cell_d[dma_q[1:0]] = wv_w;
               end else begin
                  dmw_d = wv_w;
                  dwe_d = 1'b1;
               end
            end
         end
         default: ;
      endcase
      if (last_w) begin
         unique case (cls_w)
            operand_decoder_pkg::CL_REL:
               if (cond_w) nxt_w = rel_w;
            operand_decoder_pkg::CL_FAR: begin
               nxt_w = {op_q[3:0], b1_q};
               if (op_q[`OP_DIR_BIT]) begin
                  for (int i = STACK_CELLS - 1; i > 0; i--)
                     stk_d[i] = stk_q[i - 1];
                  stk_d[0] = pc_q + 12'h002;
               end
            end
            operand_decoder_pkg::CL_BTST:
               if (tbit_q) nxt_w = pc_q + 12'h001 + {{4{b2_q[7]}}, b2_q};
            operand_decoder_pkg::CL_INH:
               if (op_q == `OP_RET) begin
                  nxt_w = stk_q[0];
                  for (int i = 0; i < STACK_CELLS - 1; i++)
                     stk_d[i] = stk_q[i + 1];
               end
            default: ;
         endcase
         pc_d  = nxt_w;
         pma_d = nxt_w;
         cyc_d = 3'h0;
      end
      fetch_d = cyc_d == 3'h0;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pc_q    <= `PC_RESET;
         pma_q   <= `PC_RESET;
         cyc_q   <= 3'h0;
         op_q    <= 8'h00;
         b1_q    <= 8'h00;
         b2_q    <= 8'h00;
         acc_q   <= `ACC_RESET;
         for (int i = 0; i < 4; i++) cell_q[i] <= `CELL_RESET;
         for (int i = 0; i < STACK_CELLS; i++) stk_q[i] <= `STACK_RESET;
         zf_q    <= 1'b0;
         cf_q    <= 1'b0;
         dma_q   <= 8'h00;
         dmw_q   <= 8'h00;
         dwe_q   <= 1'b0;
         drd_q   <= 1'b0;
         fetch_q <= 1'b1;
         tbit_q  <= 1'b0;
      end else begin
         pc_q    <= pc_d;
         pma_q   <= pma_d;
         cyc_q   <= cyc_d;
         op_q    <= op_d;
         b1_q    <= b1_d;
         b2_q    <= b2_d;
         acc_q   <= acc_d;
         cell_q  <= cell_d;
         stk_q   <= stk_d;
         zf_q    <= zf_d;
         cf_q    <= cf_d;
         dma_q   <= dma_d;
         dmw_q   <= dmw_d;
         dwe_q   <= dwe_d;
         drd_q   <= drd_d;
         fetch_q <= fetch_d;
         tbit_q  <= tbit_d;
      end
   end

   // outputs straight from flops
   assign pm_addr      = pma_q;
   assign dm_addr      = dma_q;
   assign dm_wdata     = dmw_q;
   assign dm_we        = dwe_q;
   assign dm_rd        = drd_q;
   assign acc          = acc_q;
   assign zero_flag    = zf_q;
   assign carry_flag   = cf_q;
   assign opcode_fetch = fetch_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic ld_st, is_far, is_bt;
   assign ld_st  = fetch_q && cls_w == operand_decoder_pkg::CL_LDST;
   assign is_far = !fetch_q && cls_w == operand_decoder_pkg::CL_FAR;
   assign is_bt  = fetch_q && cls_w == operand_decoder_pkg::CL_BTST;

   property p_ldst_len;
      ld_st |=> !fetch_q [*3] ##1 fetch_q;
   endproperty
   a_ldst_len: assert property (p_ldst_len) else $error("load/store not 4 cycles");
   property p_btst_len;
      is_bt |=> !fetch_q [*4] ##1 fetch_q;
   endproperty
   a_btst_len: assert property (p_btst_len) else $error("bit test not 5 cycles");
   property p_rel;
      (cyc_q == 3'h1 && !op_q[7]) |=> pc_q == ($past(cond_w) ? $past(rel_w) : $past(pc_q) + 12'h001);
   endproperty
   a_rel: assert property (p_rel) else $error("relative target wrong");
   property p_far;
      (is_far && cyc_q == 3'h3) |=> pma_q == {$past(op_q[3:0]), $past(b1_q)};
   endproperty
   a_far: assert property (p_far) else $error("far target wrong");
   property p_call;
      (is_far && cyc_q == 3'h3 && op_q[4]) |=> stk_q[0] == $past(pc_q) + 12'h002;
   endproperty
   a_call: assert property (p_call) else $error("return address wrong");
   property p_ind;
      (ld_st && pm_rdata[3:1] == 3'h4) |=> ##1 dma_q == cell_q[{1'b0, op_q[4]}];
   endproperty
   a_ind: assert property (p_ind) else $error("indirect address wrong");
   property p_dir;
      (ld_st && pm_rdata[3:1] == 3'h5) |=> ##1 dma_q == $past(pm_rdata);
   endproperty
   a_dir: assert property (p_dir) else $error("direct address wrong");
   property p_short;
      (ld_st && pm_rdata[3:2] == 2'h1) |=> ##2 cell_q[op_q[1:0]] == $past(acc_q, 3) && !dm_we;
   endproperty
   a_short: assert property (p_short) else $error("short store wrong");
   property p_imm_mem;
      (ld_st && pm_rdata[3:0] == `LDF_IMM_MEM) |=> ##2 $stable(zf_q) && $stable(cf_q);
   endproperty
   a_imm_mem: assert property (p_imm_mem) else $error("flags changed");
   property p_imm_acc;
      (ld_st && pm_rdata[3:0] == `LDF_IMM_ACC) |=> ##2 acc_q == b1_q && zf_q == (b1_q == 8'h00);
   endproperty
   a_imm_acc: assert property (p_imm_acc) else $error("immediate load wrong");
   c_call: cover property (is_far && cyc_q == 3'h3 && op_q[4]);
   c_rel:  cover property (cyc_q == 3'h1 && !op_q[7] && cond_w);
   c_bt:   cover property (is_bt ##4 tbit_q);
   c_we:   cover property (dm_we);
endmodule : mcu_operand_address_decoder
`default_nettype wire

/* logic/operand_decoder_regs.svh */
`ifndef OPERAND_DECODER_REGS_SVH
`define OPERAND_DECODER_REGS_SVH
// ----------------------------------------
// data space map
// ----------------------------------------
`define CELL_BASE_HI   6'h20
`define PTR_ONE_ADDR   8'h80
`define PTR_TWO_ADDR   8'h81
`define CELL_C_ADDR    8'h82
`define CELL_D_ADDR    8'h83
`define ACC_ADDR       8'hFF
// ----------------------------------------
// reset values
// ----------------------------------------
`define CELL_RESET     8'h00
`define ACC_RESET      8'h00
`define PC_RESET       12'h000
`define STACK_RESET    12'h000
`define STACK_DEPTH    6
// ----------------------------------------
// opcode fields and codes
// ----------------------------------------
`define OP_PTR_BIT     4
`define OP_DIR_BIT     4
`define OP_POL_BIT     3
`define CLS_FAR        2'h0
`define CLS_BIT        2'h1
`define CLS_LDST       2'h2
`define CLS_INH        2'h3
`define OP_RET         8'hE1
`define LDF_IND_LD     4'h8
`define LDF_IND_ST     4'h9
`define LDF_DIR_LD     4'hA
`define LDF_DIR_ST     4'hB
`define LDF_IMM_ACC    4'hC
`define LDF_IMM_MEM    4'hD
// ----------------------------------------
// cycles per instruction
// ----------------------------------------
`define CYC_LDST       3'h4
`define CYC_REL        3'h2
`define CYC_FAR        3'h4
`define CYC_BDIR       3'h4
`define CYC_BTST       3'h5
`define CYC_INH        3'h2
`endif

/* logic/operand_decoder_pkg.sv */
`default_nettype none
package operand_decoder_pkg;
`include "operand_decoder_regs.svh"
   typedef enum logic [5:0] {
      CL_REL  = 6'h01,
      CL_FAR  = 6'h02,
      CL_BDIR = 6'h04,
      CL_BTST = 6'h08,
      CL_LDST = 6'h10,
      CL_INH  = 6'h20
   } op_class_t;

   // top bit clear is a relative branch, else bits 6:5 pick the group
   function automatic op_class_t op_class(input logic [7:0] op);
      op_class_t c;
      c = CL_INH;
      if (!op[7]) begin
         c = CL_REL;
      end else begin
         unique case (op[6:5])
            `CLS_FAR:  c = CL_FAR;
            `CLS_BIT:  c = op[`OP_DIR_BIT] ? CL_BTST : CL_BDIR;
            `CLS_LDST: c = CL_LDST;
            `CLS_INH:  c = CL_INH;
         endcase
      end
      return c;
   endfunction : op_class

   function automatic logic [1:0] op_bytes(input logic [7:0] op);
      logic [1:0] n;
      n = 2'h1;
      unique case (op_class(op))
         CL_FAR, CL_BDIR: n = 2'h2;
         CL_BTST:         n = 2'h3;
         CL_LDST: begin
            if (op[3:0] == `LDF_IMM_MEM) n = 2'h3;
            else if (op[3:0] == `LDF_DIR_LD || op[3:0] == `LDF_DIR_ST
                     || op[3:0] == `LDF_IMM_ACC) n = 2'h2;
         end
         CL_REL, CL_INH:  n = 2'h1;
      endcase
      return n;
   endfunction : op_bytes

   function automatic logic [2:0] op_cycles(input logic [7:0] op);
      logic [2:0] n;
      n = `CYC_INH;
      unique case (op_class(op))
         CL_REL:  n = `CYC_REL;
         CL_FAR:  n = `CYC_FAR;
         CL_BDIR: n = `CYC_BDIR;
         CL_BTST: n = `CYC_BTST;
         CL_LDST: n = `CYC_LDST;
         CL_INH:  n = `CYC_INH;
      endcase
      return n;
   endfunction : op_cycles
endpackage : operand_decoder_pkg
`default_nettype wire

/* tb/prog_data_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// program space and data space memories
// ----------------------------------------
module prog_data_model (
   // clock
   input  wire logic        sys_clk,
   // program space read port
   input  wire logic [11:0] pm_addr,
   output var  logic [7:0]  pm_rdata,
   // data space bus
   input  wire logic [7:0]  dm_addr,
   input  wire logic [7:0]  dm_wdata,
   input  wire logic        dm_we,
   input  wire logic        dm_rd,
   output var  logic [7:0]  dm_rdata
);
   logic [7:0] prog_q [4096];
   logic [7:0] data_q [256];
   logic [7:0] last_q;

   // opcodes and constants answer in the same cycle, no wait state
   assign pm_rdata = prog_q[pm_addr];
   // an idle bus shows the inverse of the last read so stale data never matches
   assign dm_rdata = dm_rd ? data_q[dm_addr] : ~last_q;

   // byte writes and read history; plain always, as the initial fill writes the same arrays
   always @(posedge sys_clk) begin
      if (dm_we) begin
         data_q[dm_addr] <= dm_wdata;
      end
      if (dm_rd) begin
         last_q <= data_q[dm_addr];
      end
   end

   // blank program space decodes as an inherent no-op
   initial begin
      foreach (prog_q[k]) prog_q[k] = 8'hFF;
      foreach (data_q[k]) data_q[k] = 8'h00;
      last_q = 8'h00;
   end
endmodule : prog_data_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        sys_clk;
   logic        nrst;
   logic [11:0] pm_addr;
   logic [7:0]  pm_rdata;
   logic [7:0]  dm_addr;
   logic [7:0]  dm_wdata;
   logic        dm_we;
   logic        dm_rd;
   logic [7:0]  dm_rdata;
   logic [7:0]  acc;
   logic        zero_flag;
   logic        carry_flag;
   logic        opcode_fetch;
   int          n_mismatch;
   int          samples_checked;
   int          cycles;
   int          n_bad_bus;
   localparam int N_FETCH = 20;
   localparam int LIMIT   = 2000;
   // program image as {address, byte}
   logic [19:0] image [34] = '{20'h000CC, 20'h00141, 20'h002C4, 20'h003CC, 20'h00400,
      20'h005CD, 20'h00641, 20'h0073C, 20'h008C8, 20'h009CB, 20'h00A50, 20'h00BA9, 20'h00C50,
      20'h00DA2, 20'h00E50, 20'h00FB1, 20'h01050, 20'h01105, 20'h012BB, 20'h01350, 20'h01410,
      20'h02391, 20'h02400, 20'h025CC, 20'h02600, 20'h0278A, 20'h028BC, 20'h1000F, 20'h102E1,
      20'h11052, 20'h1117F, 20'hABCC0, 20'hABD8A, 20'hABEBD};
   logic [11:0] exp_pc [N_FETCH] = '{12'h000, 12'h002, 12'h003, 12'h005, 12'h008, 12'h009,
      12'h00B, 12'h00D, 12'h00F, 12'h012, 12'h023, 12'h100, 12'h110, 12'h111, 12'h102,
      12'h025, 12'h027, 12'hABC, 12'hABD, 12'hABD};
   logic [7:0]  exp_acc [N_FETCH] = '{8'h00, 8'h41, 8'h41, 8'h00, 8'h00, 8'h3C, 8'h3C,
      8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h00, 8'h00, 8'h41, 8'h41};
   logic [2:0]  exp_len [N_FETCH] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5,
      3'h5, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
   logic [0:19] exp_z = 20'h1800C;
   logic [0:19] exp_c = 20'h007FF;

   mcu_operand_address_decoder i_dut (
      .sys_clk(sys_clk), .nrst(nrst), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rd(dm_rd),
      .dm_rdata(dm_rdata), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
      .opcode_fetch(opcode_fetch));

   prog_data_model i_mem (
      .sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
      .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rd(dm_rd), .dm_rdata(dm_rdata));

   // ----------------------------------------
   // compare tasks and closing report
   // ----------------------------------------
   task automatic check_pc(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_pc

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // bus strobes are watched mid-cycle, where they have settled
   always @(negedge sys_clk) begin
      if ((dm_we === 1'b1 || dm_rd === 1'b1) && (dm_addr[7:2] === 6'h20 || dm_addr === 8'hFF))
         n_bad_bus++;
   end

   // cycle count and hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles >= LIMIT) begin
         n_mismatch++;
         complete_run();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int i;
      int last;
      nrst = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      cycles = 0;
      n_bad_bus = 0;
      i = 0;
      last = 0;
      // load after time zero so the model's blank fill cannot overwrite it
      repeat (12) @(posedge sys_clk);
      foreach (image[k]) i_mem.prog_q[image[k][19:8]] = image[k][7:0];
      #1 nrst = 1'b1;
      // walk the program, checking state at every opcode fetch
      while (i < N_FETCH) begin
         @(negedge sys_clk);
         if (opcode_fetch === 1'b1) begin
            check_pc(pm_addr, exp_pc[i]);
            check_byte(acc, exp_acc[i]);
            check_bit(zero_flag, exp_z[i]);
            check_bit(carry_flag, exp_c[i]);
            if (i > 0) check_byte(8'(cycles - last), {5'h00, exp_len[i-1]});
            last = cycles;
            i++;
         end
      end
      $display("test fetch trace done");
      check_byte(i_mem.data_q[8'h41], 8'h3C);
      check_byte(i_mem.data_q[8'h50], 8'h3A);
      check_byte(i_mem.data_q[8'h40], 8'h00);
      check_byte(8'(n_bad_bus), 8'h00);
      $display("test memory image done");
      // second reset in mid-run, then a clean restart from address zero
      @(posedge sys_clk);
      #1 nrst = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 nrst = 1'b1;
      @(negedge sys_clk);
      check_pc(pm_addr, 12'h000);
      check_byte(acc, 8'h00);
      check_bit(opcode_fetch, 1'b1);
      repeat (4) @(negedge sys_clk);
      check_pc(pm_addr, 12'h002);
      check_byte(acc, 8'h41);
      check_bit(zero_flag, 1'b0);
      $display("test reset done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
